// ### rtl/ttc_top.sv
// Control and status registers of the dual-tone transceiver, with burst timing
// and the shared open-drain interrupt and tone pin.
// Assumes host strobes are one clock wide and synchronous to clk_i.
`timescale 1ns/100ps
module ttc_top #(
    parameter int unsigned BURST_CYCLES = ttc_pkg::BURST_CYC_DEF
) (
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    input  wire logic                       register_select_line_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    input  wire logic [ttc_pkg::DATA_W-1:0] wdata_i,
    output logic      [ttc_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                       digit_valid_i,
    input  wire logic [ttc_pkg::DATA_W-1:0] digit_code_i,
    input  wire logic                       tone_gone_i,
    input  wire logic                       call_progress_wave_i,
    output logic                            tone_on_o,
    output logic      [ttc_pkg::DATA_W-1:0] tone_code_o,
    output logic                            single_tone_o,
    output logic                            column_tone_o,
    output logic                            interrupt_tone_pin_o,
    output logic                            interrupt_tone_pin_oe_n_o
);
    import ttc_pkg::*;

    logic [3:0]    control_reg_primary_q;
    logic [3:0]    control_reg_primary_d;
    logic [3:0]    control_reg_secondary_q;
    logic [3:0]    control_reg_secondary_d;
    logic          sec_route_q;
    logic          sec_route_d;
    logic [3:0]    tx_code_q;
    logic [3:0]    tx_code_d;
    logic [3:0]    rx_code_q;
    logic [3:0]    rx_code_d;
    logic [3:0]    rdata_q;
    logic [3:0]    rdata_d;
    logic          tx_empty_q;
    logic          tx_empty_d;
    logic          rx_full_q;
    logic          rx_full_d;
    logic          irq_flag_q;
    logic          irq_flag_d;
    logic          dsteer_q;
    logic          dsteer_d;
    ttc_tx_state_t tx_state_q;
    ttc_tx_state_t tx_state_d;

    logic               tone_en;
    logic               call_progress;
    logic               irq_en;
    logic               burst_off;
    logic               test_mode;
    logic               ctrl_wr;
    logic               data_wr;
    logic               status_rd;
    logic               timer_start;
    logic               timer_stop;
    logic               timer_done;
    logic [TIMER_W-1:0] timer_len;
    logic               pull_low;

    assign tone_en       = control_reg_primary_q[PRI_TONE_EN];
    assign call_progress = control_reg_primary_q[PRI_MODE];
    assign irq_en        = control_reg_primary_q[PRI_IRQ_EN];
    assign burst_off     = control_reg_secondary_q[SEC_BURST_OFF];
    assign test_mode     = control_reg_secondary_q[SEC_TEST];

    assign ctrl_wr   = wr_i && (register_select_line_i == SEL_CTRL);
    assign data_wr   = wr_i && (register_select_line_i == SEL_DATA);
    assign status_rd = rd_i && (register_select_line_i == SEL_CTRL);

    // Control registers and write routing
    always_comb begin
        control_reg_primary_d   = control_reg_primary_q;
        control_reg_secondary_d = control_reg_secondary_q;
        sec_route_d             = sec_route_q;
        tx_code_d               = tx_code_q;
        if (ctrl_wr) begin
            if (sec_route_q) begin
                control_reg_secondary_d = wdata_i; // RULE24
                sec_route_d             = 1'b0; // RULE8
            end else begin
                control_reg_primary_d = wdata_i; // RULE24
                sec_route_d           = wdata_i[PRI_SEC_SEL]; // RULE7
            end
        end
        if (data_wr) begin
            tx_code_d = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            control_reg_primary_q   <= CTRL_RESET;
            control_reg_secondary_q <= CTRL_RESET;
            sec_route_q             <= 1'b0;
            tx_code_q               <= CODE_RESET;
        end else begin
            control_reg_primary_q   <= control_reg_primary_d;
            control_reg_secondary_q <= control_reg_secondary_d;
            sec_route_q             <= sec_route_d;
            tx_code_q               <= tx_code_d;
        end
    end

    // Burst sequencer: burst then equal pause per written digit
    assign timer_len = call_progress ? TIMER_W'(BURST_CYCLES * EXT_FACTOR) // RULE12
                                     : TIMER_W'(BURST_CYCLES);
    assign timer_stop = burst_off || !tone_en;

    always_comb begin
        tx_state_d  = tx_state_q;
        timer_start = 1'b0;
        case (tx_state_q)
            TX_IDLE: begin
                if (data_wr && tone_en && !burst_off) begin // RULE9
                    tx_state_d  = TX_BURST; // RULE10
                    timer_start = 1'b1;
                end
            end
            TX_BURST: begin
                if (timer_stop) begin
                    tx_state_d = TX_IDLE;
                end else if (timer_done) begin
                    tx_state_d  = TX_PAUSE; // RULE10
                    timer_start = 1'b1;
                end
            end
            TX_PAUSE: begin
                if (timer_stop || timer_done) begin
                    tx_state_d = TX_IDLE;
                end
            end
            default: begin
                tx_state_d = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_state_q <= TX_IDLE;
        end else begin
            tx_state_q <= tx_state_d;
        end
    end

    ttc_timer #(
        .W (TIMER_W)
    ) u_timer (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .start_i  (timer_start),
        .stop_i   (timer_stop),
        .len_i    (timer_len),
        .done_o   (timer_done)
    );

    // Status flags; a new event wins over the clear by a status read
    always_comb begin
        tx_empty_d = tx_empty_q && !status_rd && !burst_off; // RULE18
        if (tx_state_q == TX_PAUSE && timer_done && !timer_stop) begin
            tx_empty_d = 1'b1; // RULE11
        end
        rx_full_d = rx_full_q && !status_rd;
        rx_code_d = rx_code_q;
        if (digit_valid_i && !call_progress) begin // RULE4
            rx_full_d = 1'b1; // RULE19
            rx_code_d = digit_code_i; // RULE21
        end
        irq_flag_d = tx_empty_d || rx_full_d; // RULE17
        dsteer_d   = dsteer_q;
        if (digit_valid_i) begin
            dsteer_d = 1'b0; // RULE20
        end else if (tone_gone_i) begin
            dsteer_d = 1'b1; // RULE20
        end
        rdata_d = rdata_q;
        if (rd_i) begin
            rdata_d = (register_select_line_i == SEL_CTRL)
                    ? {dsteer_q, rx_full_q, tx_empty_q, irq_flag_q}
                    : rx_code_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_empty_q <= 1'b0;
            rx_full_q  <= 1'b0;
            irq_flag_q <= 1'b0;
            dsteer_q   <= 1'b0;
            rx_code_q  <= CODE_RESET;
            rdata_q    <= CODE_RESET;
        end else begin
            tx_empty_q <= tx_empty_d; // RULE24
            rx_full_q  <= rx_full_d;
            irq_flag_q <= irq_flag_d;
            dsteer_q   <= dsteer_d;
            rx_code_q  <= rx_code_d;
            rdata_q    <= rdata_d;
        end
    end

    // Shared pin selection
    always_comb begin
        pull_low = 1'b0;
        if (call_progress) begin // RULE2
            pull_low = irq_en && !call_progress_wave_i; // RULE3
        end else if (test_mode) begin
            pull_low = !dsteer_q; // RULE14
        end else begin
            pull_low = irq_en && irq_flag_q; // RULE5 RULE6
        end
    end

    assign interrupt_tone_pin_o      = 1'b0; // RULE22
    assign interrupt_tone_pin_oe_n_o = !pull_low; // RULE22

    assign tone_on_o     = tone_en && (burst_off || tx_state_q == TX_BURST); // RULE1 RULE13
    assign tone_code_o   = tx_code_q;
    assign single_tone_o = control_reg_secondary_q[SEC_SINGLE]; // RULE15
    assign column_tone_o = control_reg_secondary_q[SEC_COLUMN]; // RULE16
    assign rdata_o       = rdata_q;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence burst_ends_s;
        tx_state_q == TX_BURST && timer_done && !timer_stop;
    endsequence

    sequence pause_ends_s;
        tx_state_q == TX_PAUSE && timer_done && !timer_stop;
    endsequence

    tone_off_gate_a: assert property (!tone_en |-> !tone_on_o) // RULE1
        else $error("tone active while tone enable is clear");
    progress_no_digit_a: assert property ( // RULE4
        call_progress && digit_valid_i && !status_rd && !rx_full_q |=> !rx_full_q)
        else $error("digit reported in call progress mode");
    route_secondary_a: assert property ( // RULE7
        ctrl_wr && !sec_route_q && wdata_i[PRI_SEC_SEL] |=> sec_route_q)
        else $error("secondary route not armed");
    route_back_a: assert property ( // RULE8
        ctrl_wr && sec_route_q |=> !sec_route_q && control_reg_secondary_q == $past(wdata_i))
        else $error("secondary write misrouted");
    burst_to_pause_a: assert property (burst_ends_s |=> tx_state_q == TX_PAUSE && !tone_on_o) // RULE10
        else $error("burst did not turn into pause");
    pause_sets_empty_a: assert property ( // RULE11
        pause_ends_s ##1 (irq_en && !call_progress && !test_mode)
        |-> tx_empty_q && !interrupt_tone_pin_oe_n_o)
        else $error("pause end did not flag transmitter empty");
    ext_timing_a: assert property ( // RULE12
        timer_start && call_progress |=> u_timer.cnt_q == TIMER_W'(BURST_CYCLES * EXT_FACTOR))
        else $error("call progress burst not extended");
    steady_tone_a: assert property (burst_off && tone_en |-> tone_on_o) // RULE13
        else $error("non-burst tone not following enable");
    test_pin_a: assert property ( // RULE14
        test_mode && !call_progress |-> interrupt_tone_pin_oe_n_o == dsteer_q)
        else $error("test pin not following delayed steering");
    read_clears_a: assert property ( // RULE17
        status_rd && !digit_valid_i && !timer_done |=> !irq_flag_q && !rx_full_q)
        else $error("status read did not clear flags");
    rx_capture_a: assert property ( // RULE19
        digit_valid_i && !call_progress |=> rx_full_q && rx_code_q == $past(digit_code_i))
        else $error("valid digit not captured");
    dsteer_set_a: assert property (tone_gone_i && !digit_valid_i |=> dsteer_q) // RULE20
        else $error("delayed steering not set");
    progress_wave_a: assert property ( // RULE3
        call_progress && irq_en |-> interrupt_tone_pin_oe_n_o == call_progress_wave_i)
        else $error("call progress wave not on pin");

endmodule

// ### rtl/ttc_pkg.sv
// Constants shared by the tone transceiver control and status logic.
// Assumes a single 20 MHz clock and synchronous host strobes.
// Behaviour
// RULE1 - Tone enable bit gates all transmit tones
// RULE2 - Mode bit picks call progress or dual-tone
// RULE3 - Call progress wave drives shared pin
// RULE4 - No digit reports in call progress mode
// RULE5 - Interrupt enable bit gates pin events
// RULE6 - Pin low on digit or transmitter ready
// RULE7 - Select bit routes next write secondary
// RULE8 - After secondary write, route back primary
// RULE9 - Secondary bit zero low enables burst
// RULE10 - Each digit gives equal burst and pause
// RULE11 - Pause end sets empty, raises interrupt
// RULE12 - Call progress mode doubles burst timing
// RULE13 - Non-burst tone follows enable bit only
// RULE14 - Test mode pin follows delayed steering
// RULE15 - Secondary bit two picks single tone
// RULE16 - Secondary bit three picks column tone
// RULE17 - Interrupt flag mirrors empty or full
// RULE18 - Empty set at pause end, cleared
// RULE19 - Full set on valid digit, read clears
// RULE20 - Delayed steering set absent, cleared present
// RULE21 - Receive register holds last valid digit
// RULE22 - Shared pin is open drain, low only
// RULE23 - Host initialises control registers after power-up
// RULE24 - Registers hold; flags update on clock
package ttc_pkg;

    localparam int unsigned DATA_W = 4;

    // Register select line values
    localparam logic SEL_DATA = 1'b0;
    localparam logic SEL_CTRL = 1'b1;

    // Primary control field positions
    localparam int unsigned PRI_TONE_EN = 0;
    localparam int unsigned PRI_MODE    = 1;
    localparam int unsigned PRI_IRQ_EN  = 2;
    localparam int unsigned PRI_SEC_SEL = 3;

    // Secondary control field positions
    localparam int unsigned SEC_BURST_OFF = 0;
    localparam int unsigned SEC_TEST      = 1;
    localparam int unsigned SEC_SINGLE    = 2;
    localparam int unsigned SEC_COLUMN    = 3;

    // Status field positions
    localparam int unsigned ST_IRQ    = 0;
    localparam int unsigned ST_TX_MT  = 1;
    localparam int unsigned ST_RX_FUL = 2;
    localparam int unsigned ST_DSTEER = 3;

    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] CODE_RESET = 4'h0;

    // Burst timing
    localparam int unsigned CLK_KHZ       = 20000;
    localparam int unsigned BURST_MS      = 51;
    localparam int unsigned EXT_FACTOR    = 2;
    localparam int unsigned BURST_CYC_DEF = BURST_MS * CLK_KHZ;
    localparam int unsigned TIMER_W       = 22;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_BURST = 2'b01,
        TX_PAUSE = 2'b11
    } ttc_tx_state_t;

endpackage

// ### rtl/ttc_timer.sv
// Down counter that times one tone burst or pause.
// Assumes start is a single-cycle request from the controller; stop is a level held while it applies.
`timescale 1ns/100ps
module ttc_timer #(
    parameter int unsigned W = 22
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         start_i,
    input  wire logic         stop_i,
    input  wire logic [W-1:0] len_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_q;
    logic         done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (stop_i) begin
            cnt_d = '0;
        end else if (start_i) begin
            cnt_d = len_i;
        end else if (cnt_q != '0) begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == W'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;

endmodule

// ### verif/ttc_host_model.sv
// Host processor model driving the register port of the transceiver.
// Assumes the bench calls its tasks; all strobes change at the falling edge.
`timescale 1ns/100ps
module ttc_host_model (
    input  wire logic                       clk_i,
    input  wire logic [ttc_pkg::DATA_W-1:0] rdata_i,
    output logic                            rs_o,
    output logic                            wr_o,
    output logic                            rd_o,
    output logic      [ttc_pkg::DATA_W-1:0] wdata_o
);
    import ttc_pkg::*;

    initial begin
        rs_o    = SEL_CTRL;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 4'h0;
    end

    // One write or read; a read returns once rdata has surely settled
    task automatic access(input logic rs, input logic wr, input logic [3:0] d,
                          output logic [3:0] q);
        @(negedge clk_i);
        rs_o    = rs;
        wr_o    = wr;
        rd_o    = ~wr;
        wdata_o = wr ? d : ~d;
        @(negedge clk_i);
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = ~wdata_o;
        q       = 4'h0;
        if (!wr) begin
            @(negedge clk_i);
            q = rdata_i;
        end
    endtask

    // Start-up control sequence before any setting is relied on
    task automatic init();
        logic [3:0] q;
        access(SEL_CTRL, 1'b0, 4'h0, q);
        access(SEL_CTRL, 1'b1, 4'h0, q);
        access(SEL_CTRL, 1'b1, 4'h0, q);
        access(SEL_CTRL, 1'b1, 4'h8, q);
        access(SEL_CTRL, 1'b1, 4'h0, q);
        access(SEL_CTRL, 1'b0, 4'h0, q);
    endtask
endmodule

// ### verif/test_tone_transceiver_ctrl_status.sv
// Self-checking bench for the transceiver control and status registers.
// Assumes the host model on the register port; receiver inputs come from here.
`timescale 1ns/100ps
module test_tone_transceiver_ctrl_status;
    import ttc_pkg::*;
    localparam int unsigned B = 20;
    logic       clk;
    logic       resetn;
    logic       rs;
    logic       wr;
    logic       rd;
    logic       dv;
    logic       tg;
    logic       cpw;
    logic       ton;
    logic       sgl;
    logic       col;
    logic       pin;
    logic       oe_n;
    logic [3:0] wd;
    logic [3:0] rdata;
    logic [3:0] dcode;
    logic [3:0] tcode;
    logic [3:0] q;
    logic [3:0] code;
    int         errors;
    int         checked;
    int         n;

    ttc_host_model host (.clk_i(clk), .rdata_i(rdata), .rs_o(rs), .wr_o(wr),
                         .rd_o(rd), .wdata_o(wd));

    ttc_top #(.BURST_CYCLES(B)) uut (
        .clk_i(clk), .resetn_i(resetn), .register_select_line_i(rs),
        .wr_i(wr), .rd_i(rd), .wdata_i(wd), .rdata_o(rdata),
        .digit_valid_i(dv), .digit_code_i(dcode), .tone_gone_i(tg),
        .call_progress_wave_i(cpw), .tone_on_o(ton), .tone_code_o(tcode),
        .single_tone_o(sgl), .column_tone_o(col), .interrupt_tone_pin_o(pin),
        .interrupt_tone_pin_oe_n_o(oe_n));

    always #25 clk = ~clk;

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Status word expected from delayed steering, rx full and tx empty
    function automatic logic [3:0] st(input logic d, input logic r, input logic t);
        return {d, r, t, r | t};
    endfunction

    task automatic wc(input logic [3:0] d);
        host.access(SEL_CTRL, 1'b1, d, q);
    endtask

    task automatic rx_evt(input logic gone, input logic [3:0] c);
        @(negedge clk);
        tg    = gone;
        dv    = ~gone;
        dcode = c;
        @(negedge clk);
        tg    = 1'b0;
        dv    = 1'b0;
        dcode = ~c;
    endtask

    // Counts cycles while the tone (or the released pin) stays high
    task automatic wait_hi(input logic use_ton);
        n = 0;
        while ((use_ton ? ton : oe_n) === 1'b1 && n < 9 * B) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9 * B) begin
            errors++;
            finish_test();
        end
    endtask

    task automatic burst(input int m);
        code = 4'($urandom);
        host.access(SEL_DATA, 1'b1, code, q);
        chk(tcode, code);
        chk(ton, 1'b1);
        wait_hi(1'b1);
        chk(n >= m * B - 1 && n <= m * B + 2, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        dv = 1'b0;
        tg = 1'b0;
        cpw = 1'b0;
        dcode = 4'h0;
        errors = 0;
        checked = 0;
        void'($urandom(55));
        repeat (2) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        chk(ton, 1'b0);
        chk(oe_n, 1'b1);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, 4'h0);
        host.init();
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            wc(4'h8);
            wc(4'(i << 2));
            chk(sgl, 4'(i & 1));
            chk(col, 4'(i >> 1));
            wc(4'h0);
            chk({col, sgl}, 4'(i));
        end
        $display("test routing done");

        wc(4'h5);
        burst(1);
        wait_hi(1'b0);
        chk(n >= B - 1 && n <= B + 3, 1'b1);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, st(1'b0, 1'b0, 1'b1));
        chk(oe_n, 1'b1);
        host.access(SEL_DATA, 1'b1, 4'h9, q);
        wc(4'h4);
        chk(ton, 1'b0);
        repeat (3 * B) @(negedge clk);
        chk(oe_n, 1'b1);
        $display("test burst done");

        wc(4'h3);
        burst(2);
        repeat (3 * B) @(negedge clk);
        chk(oe_n, 1'b1);
        wc(4'h9);
        wc(4'h1);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, 4'h0);
        wc(4'h1);
        repeat (3 * B) @(negedge clk);
        chk(ton, 1'b1);
        wc(4'h0);
        chk(ton, 1'b0);
        $display("test timing done");

        code = 4'($urandom);
        rx_evt(1'b0, code);
        chk(oe_n, 1'b1);
        wc(4'h4);
        chk(oe_n, 1'b0);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        host.access(SEL_DATA, 1'b0, 4'h0, q);
        chk(q, code);
        rx_evt(1'b1, 4'h0);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, st(1'b1, 1'b0, 1'b0));
        wc(4'h6);
        rx_evt(1'b0, ~code);
        host.access(SEL_CTRL, 1'b0, 4'h0, q);
        chk(q, 4'h0);
        host.access(SEL_DATA, 1'b0, 4'h0, q);
        chk(q, code);
        repeat (8) begin
            @(negedge clk);
            cpw = 1'($urandom);
            #1;
            chk(oe_n, cpw);
            chk(pin, 1'b0);
        end
        cpw = 1'b0;
        $display("test receive done");

        wc(4'h8);
        wc(4'h2);
        rx_evt(1'b1, 4'h0);
        chk(oe_n, 1'b1);
        rx_evt(1'b0, code);
        chk(oe_n, 1'b0);
        $display("test test-mode done");
        finish_test();
    end
endmodule
